// ---- sucal_top.sv ----
`timescale 1ns/1ps
// Operation
// R1 - questionable node uses bit 8 only
// R2 - enabled falling condition sets event bit
// R3 - enabled rising condition sets event bit
// R4 - negative filter query returns stored value
// R5 - positive filter query returns stored value
// R6 - preset: enables 0, ptr 1, ntr 0
// R7 - error read pops oldest, empty gives 0
// R8 - error codes are signed 16 bit
// R9 - cal entry only via remote commands
// R10 - controller sends start wavelength and step
// R11 - start >= 1200nm, step 0.1 to 10nm
// R12 - count 10..401, last point <= 1650nm
// R13 - bad start parameters queue error -221
// R14 - cal on refuses start, error 201
// R15 - controller loops points then sends stop
// R16 - event read clears, condition read keeps
// R17 - enabled event drives status byte bit 3
// R18 - filters all disabled at power-on
// R19 - event bits sticky until read
// R20 - summary is OR of masked events
module sucal_top (
  input wire logic aclk, // 100 MHz clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write answer
  output logic s_axi_bvalid, // write answer valid
  input wire logic s_axi_bready, // write answer taken
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read answer
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data taken
  input wire logic [31:0] set_wl_pm, // set wavelength, same clock
  input wire logic remote_pin, // high while under remote control
  output logic stb_ques_summary, // status byte bit 3
  output logic user_wavelength_cal_entry // cal entry in progress
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sucal_pkg::sucal_node_s ques; // questionable filters
  sucal_pkg::sucal_node_s oper; // operation filters
  sucal_pkg::sucal_params_s par; // start parameters as written
  logic [15:0] ques_cond; // live condition
  logic [15:0] ques_prev; // condition one cycle ago
  logic [15:0] ques_event; // sticky events
  logic user_wavelength_cal_on; // user cal selected
  logic cal_valid; // a range has been accepted
  logic [31:0] cal_lo_pm; // range low end
  logic [31:0] cal_hi_pm; // range high end
  logic remote_meta; // synchroniser first stage
  logic remote_sync; // synchroniser second stage
  logic [7:0] aw_q; // held write address
  logic [31:0] w_q; // held write data
  logic [3:0] ws_q; // held byte enables
  logic aw_full, w_full; // address and data halves held
  logic next_aw_full, next_w_full, next_bvalid; // next handshake state
  logic do_write; // both halves present
  logic rd_take; // read address taken
  logic wr_hit; // write address mapped
  logic rd_hit; // read address mapped
  logic [31:0] rd_mux; // read value
  logic [31:0] merged; // held data merged under strobes
  logic [31:0] old_word; // word being overwritten
  logic evt_read; // event register read this cycle
  logic err_read; // error register read this cycle
  logic cmd_wr, preset_cmd, start_cmd, stop_cmd; // command strobes
  logic [24:0] span_pm; // (count-1) * step
  logic [32:0] last_pm; // final point wavelength
  logic params_ok; // all limit checks pass
  logic err_push; // enqueue strobe
  logic signed [15:0] err_code; // code to enqueue
  logic signed [15:0] err_head; // oldest queued code
  logic err_any; // queue holds something

  // ----------------------------------------------------------------
  // remote pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      remote_meta <= 1'b0;
      remote_sync <= 1'b0;
    end else begin
      remote_meta <= remote_pin;
      remote_sync <= remote_meta;
    end
  end

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  assign do_write = aw_full && w_full && !s_axi_bvalid;
  assign wr_hit = (aw_q[1:0] == 2'h0) && (aw_q <= sucal_pkg::ERR_OFS);
  assign cmd_wr = do_write && (aw_q == sucal_pkg::CMD_OFS) && ws_q[0];
  assign preset_cmd = cmd_wr && w_q[sucal_pkg::CMD_PRESET_BIT];
  // start and stop only ever arrive as bus commands, gated by remote mode
  assign start_cmd = cmd_wr && w_q[sucal_pkg::CMD_START_BIT] && remote_sync; // R9
  assign stop_cmd = cmd_wr && w_q[sucal_pkg::CMD_STOP_BIT] && remote_sync; // R9

  // next state of the two-sided write handshake
  always_comb begin
    next_aw_full = aw_full;
    next_w_full = w_full;
    next_bvalid = s_axi_bvalid;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_full = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_full = 1'b1;
    end
    if (do_write) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  // write handshake flops; ready drops while a write is in hand
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sucal_pkg::RESP_OKAY;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      s_axi_bvalid <= next_bvalid;
      s_axi_awready <= !next_aw_full && !next_bvalid;
      s_axi_wready <= !next_w_full && !next_bvalid;
      if (do_write) begin
        s_axi_bresp <= wr_hit ? sucal_pkg::RESP_OKAY : sucal_pkg::RESP_SLVERR;
      end
    end
  end

  // held address and data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= '0;
      w_q <= '0;
      ws_q <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
    end
  end

  // register word by address, shared by the read path and the write merge
  function automatic logic [31:0] reg_word(input logic [7:0] a);
    unique case (a)
      sucal_pkg::QCOND_OFS: return 32'(ques_cond); // R16
      sucal_pkg::QEVENT_OFS: return 32'(ques_event);
      sucal_pkg::QENABLE_OFS: return 32'(ques.enable);
      sucal_pkg::QPTR_OFS: return 32'(ques.ptr); // R5
      sucal_pkg::QNTR_OFS: return 32'(ques.ntr); // R4
      sucal_pkg::OENABLE_OFS: return 32'(oper.enable);
      sucal_pkg::OPTR_OFS: return 32'(oper.ptr);
      sucal_pkg::ONTR_OFS: return 32'(oper.ntr);
      sucal_pkg::UCAL_STATE_OFS: return 32'(user_wavelength_cal_on);
      sucal_pkg::UCAL_START_OFS: return par.start_pm;
      sucal_pkg::UCAL_STEP_OFS: return par.step_pm;
      sucal_pkg::UCAL_COUNT_OFS: return 32'(par.count);
      sucal_pkg::STATUS_OFS: return {29'h0, remote_sync, err_any, user_wavelength_cal_entry};
      sucal_pkg::ERR_OFS: return {{16{err_head[15]}}, err_head}; // R8
      default: return '0;
    endcase
  endfunction
  // old word under the write; read-only words are never stored back
  always_comb old_word = reg_word(aw_q);
  // byte-lane merge of the held write data over the old word
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign merged[8*i +: 8] = ws_q[i] ? w_q[8*i +: 8] : old_word[8*i +: 8];
  end

  // ----------------------------------------------------------------
  // node filters and enables; preset beats a plain write
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ques <= '{sucal_pkg::ENABLE_RESET, sucal_pkg::FILTER_RESET, sucal_pkg::FILTER_RESET}; // R18
      oper <= '{sucal_pkg::ENABLE_RESET, sucal_pkg::FILTER_RESET, sucal_pkg::FILTER_RESET}; // R18
    end else if (preset_cmd) begin
      ques <= '{sucal_pkg::PRESET_ENABLE, sucal_pkg::PRESET_PTR, sucal_pkg::PRESET_NTR}; // R6
      oper <= '{sucal_pkg::PRESET_ENABLE, sucal_pkg::PRESET_PTR, sucal_pkg::PRESET_NTR}; // R6
    end else if (do_write) begin
      unique case (aw_q)
        sucal_pkg::QENABLE_OFS: ques.enable <= merged[15:0];
        sucal_pkg::QPTR_OFS: ques.ptr <= merged[15:0];
        sucal_pkg::QNTR_OFS: ques.ntr <= merged[15:0];
        sucal_pkg::OENABLE_OFS: oper.enable <= merged[15:0];
        sucal_pkg::OPTR_OFS: oper.ptr <= merged[15:0];
        sucal_pkg::ONTR_OFS: oper.ntr <= merged[15:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // user-cal parameters, state and entry checks
  // ----------------------------------------------------------------
  assign span_pm = 25'((par.count - 16'h0001) * par.step_pm[15:0]);
  assign last_pm = {1'b0, par.start_pm} + {8'h00, span_pm};
  // step upper bits guard the narrowed product above
  assign params_ok = (par.start_pm >= sucal_pkg::WL_START_MIN_PM) // R11
                     && (par.step_pm >= sucal_pkg::STEP_MIN_PM) // R11
                     && (par.step_pm <= sucal_pkg::STEP_MAX_PM) // R11
                     && (par.count >= sucal_pkg::COUNT_MIN) // R12
                     && (par.count <= sucal_pkg::COUNT_MAX) // R12
                     && (last_pm <= {1'b0, sucal_pkg::WL_STOP_MAX_PM}); // R12

  // refusal order: cal switched on first, then bad parameters
  always_comb begin
    err_push = 1'b0;
    err_code = sucal_pkg::ERR_NONE;
    if (start_cmd && user_wavelength_cal_on) begin
      err_push = 1'b1;
      err_code = sucal_pkg::ERR_CAL_ON; // R14
    end else if (start_cmd && !params_ok) begin
      err_push = 1'b1;
      err_code = sucal_pkg::ERR_PARAM; // R13
    end else if (stop_cmd && !user_wavelength_cal_entry) begin
      err_push = 1'b1;
      err_code = sucal_pkg::ERR_NOT_STARTED;
    end
  end

  // parameter words and state selection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      par <= '0;
      user_wavelength_cal_on <= 1'b0;
    end else if (do_write) begin
      unique case (aw_q)
        sucal_pkg::UCAL_START_OFS: par.start_pm <= merged;
        sucal_pkg::UCAL_STEP_OFS: par.step_pm <= merged;
        sucal_pkg::UCAL_COUNT_OFS: par.count <= merged[15:0];
        sucal_pkg::UCAL_STATE_OFS: user_wavelength_cal_on <= merged[0];
        default: ;
      endcase
    end
  end

  // accepted start opens entry and fixes the covered range
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      user_wavelength_cal_entry <= 1'b0;
      cal_valid <= 1'b0;
      cal_lo_pm <= '0;
      cal_hi_pm <= '0;
    end else if (start_cmd && !user_wavelength_cal_on && params_ok) begin
      user_wavelength_cal_entry <= 1'b1;
      cal_valid <= 1'b1;
      cal_lo_pm <= par.start_pm;
      cal_hi_pm <= last_pm[31:0];
    end else if (stop_cmd) begin
      user_wavelength_cal_entry <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // questionable node: condition, edges, sticky events
  // ----------------------------------------------------------------
  always_comb begin
    ques_cond = '0;
    ques_cond[sucal_pkg::QUES_WL_BIT] = cal_valid
        && ((set_wl_pm < cal_lo_pm) || (set_wl_pm > cal_hi_pm)); // R1
  end

  // the set term is last so an edge in the read cycle is kept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ques_prev <= '0;
      ques_event <= '0;
    end else begin
      ques_prev <= ques_cond;
      ques_event <= ((evt_read ? 16'h0000 : ques_event) // R16 R19
                    | (ques.ptr & ques_cond & ~ques_prev) // R3
                    | (ques.ntr & ~ques_cond & ques_prev)) // R2
                    & sucal_pkg::QUES_USED_MASK; // R1
    end
  end

  // summary registered so the output is a flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stb_ques_summary <= 1'b0;
    end else begin
      stb_ques_summary <= |(ques_event & ques.enable); // R17 R20
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign rd_hit = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr <= sucal_pkg::ERR_OFS);
  assign evt_read = rd_take && (s_axi_araddr == sucal_pkg::QEVENT_OFS); // R16
  assign err_read = rd_take && (s_axi_araddr == sucal_pkg::ERR_OFS); // R7

  // read mux; the filters come back exactly as stored
  always_comb rd_mux = reg_word(s_axi_araddr); // R4 R5

  // one read at a time; arready low until the data is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= sucal_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? sucal_pkg::RESP_OKAY : sucal_pkg::RESP_SLVERR;
      s_axi_arready <= 1'b0;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_arready <= !s_axi_rvalid;
    end
  end

  // ----------------------------------------------------------------
  // error queue
  // ----------------------------------------------------------------
  sucal_errq u_errq (
    .aclk (aclk),
    .aresetn (aresetn),
    .push (err_push),
    .push_code (err_code),
    .pop (err_read),
    .head_code (err_head),
    .not_empty (err_any)
  );

endmodule // sucal_top

// ---- sucal_pkg.sv ----
// ----------------------------------------------------------------
// shared constants and carriers for the status / user-cal block
// ----------------------------------------------------------------
package sucal_pkg;

  // ----------------------------------------------------------------
  // register byte offsets, one aligned 32-bit word each
  // ----------------------------------------------------------------
  localparam logic [7:0] QCOND_OFS = 8'h00; // questionable condition, read only
  localparam logic [7:0] QEVENT_OFS = 8'h04; // questionable event, clear on read
  localparam logic [7:0] QENABLE_OFS = 8'h08; // questionable enable
  localparam logic [7:0] QPTR_OFS = 8'h0c; // questionable positive filter
  localparam logic [7:0] QNTR_OFS = 8'h10; // questionable negative filter
  localparam logic [7:0] OENABLE_OFS = 8'h14; // operation enable
  localparam logic [7:0] OPTR_OFS = 8'h18; // operation positive filter
  localparam logic [7:0] ONTR_OFS = 8'h1c; // operation negative filter
  localparam logic [7:0] CMD_OFS = 8'h20; // command strobes, reads zero
  localparam logic [7:0] UCAL_STATE_OFS = 8'h24; // user cal on/off
  localparam logic [7:0] UCAL_START_OFS = 8'h28; // start wavelength, pm
  localparam logic [7:0] UCAL_STEP_OFS = 8'h2c; // step size, pm
  localparam logic [7:0] UCAL_COUNT_OFS = 8'h30; // point count
  localparam logic [7:0] STATUS_OFS = 8'h34; // block status, read only
  localparam logic [7:0] ERR_OFS = 8'h38; // error queue head, pops on read

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CMD_PRESET_BIT = 0; // status preset strobe
  localparam int CMD_START_BIT = 1; // begin user-cal entry strobe
  localparam int CMD_STOP_BIT = 2; // end user-cal entry strobe
  localparam int QUES_WL_BIT = 8; // wavelength outside cal range
  localparam int STB_QUES_BIT = 3; // status byte bit fed by node
  localparam logic [15:0] QUES_USED_MASK = 16'h0100; // only bit 8 lives

  // ----------------------------------------------------------------
  // reset and preset values
  // ----------------------------------------------------------------
  localparam logic [15:0] FILTER_RESET = 16'h0000; // filters off at power-on
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [15:0] PRESET_ENABLE = 16'h0000;
  localparam logic [15:0] PRESET_PTR = 16'hffff;
  localparam logic [15:0] PRESET_NTR = 16'h0000;

  // ----------------------------------------------------------------
  // user-cal limits, wavelengths in picometres
  // ----------------------------------------------------------------
  localparam logic [31:0] WL_START_MIN_PM = 32'h0012_4f80; // 1200 nm
  localparam logic [31:0] WL_STOP_MAX_PM = 32'h0019_2d50; // 1650 nm
  localparam logic [31:0] STEP_MIN_PM = 32'h0000_0064; // 0.1 nm
  localparam logic [31:0] STEP_MAX_PM = 32'h0000_2710; // 10 nm
  localparam logic [15:0] COUNT_MIN = 16'h000a; // 10 points
  localparam logic [15:0] COUNT_MAX = 16'h0191; // 401 points

  // ----------------------------------------------------------------
  // error codes, signed 16 bit
  // ----------------------------------------------------------------
  localparam logic signed [15:0] ERR_NONE = 16'sh0000;
  localparam logic signed [15:0] ERR_PARAM = 16'shff23; // -221
  localparam logic signed [15:0] ERR_CAL_ON = 16'sh00c9; // 201
  localparam logic signed [15:0] ERR_NOT_STARTED = 16'sh00cb; // 203
  localparam int ERRQ_DEPTH = 8; // error queue entries
  localparam int ERRQ_AW = 3; // index width

  // ----------------------------------------------------------------
  // axi answers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] enable; // gates events onto summary
    logic [15:0] ptr; // rising-edge filter
    logic [15:0] ntr; // falling-edge filter
  } sucal_node_s;

  typedef struct packed {
    logic [31:0] start_pm; // first point
    logic [31:0] step_pm; // spacing
    logic [15:0] count; // number of points
  } sucal_params_s;

endpackage

// ---- sucal_errq.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// error queue: oldest entry first, new entries dropped when full
// ----------------------------------------------------------------
module sucal_errq (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic push, // one-cycle enqueue strobe
  input wire logic signed [15:0] push_code, // code to enqueue
  input wire logic pop, // one-cycle dequeue strobe
  output logic signed [15:0] head_code, // oldest code, 0 when empty
  output logic not_empty // at least one entry held
);

  logic signed [15:0] slot [sucal_pkg::ERRQ_DEPTH]; // entry storage
  logic [sucal_pkg::ERRQ_AW-1:0] rd_idx; // oldest entry
  logic [sucal_pkg::ERRQ_AW-1:0] wr_idx; // next free slot
  logic [sucal_pkg::ERRQ_AW:0] fill; // entries held
  logic do_pop; // pop only what exists
  logic do_push; // push only where room is

  // a pop on an empty queue is harmless and reads the no-error code
  assign do_pop = pop && (fill != '0);
  // keep the oldest errors; late ones are lost rather than overwriting
  assign do_push = push && ((fill != (sucal_pkg::ERRQ_AW+1)'(sucal_pkg::ERRQ_DEPTH)) || do_pop);
  assign head_code = (fill != '0) ? slot[rd_idx] : sucal_pkg::ERR_NONE; // R7
  assign not_empty = (fill != '0);

  // storage written by index
  always_ff @(posedge aclk) begin
    if (do_push) begin
      slot[wr_idx] <= push_code; // R8
    end
  end

  // pointers and fill level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_idx <= '0;
      wr_idx <= '0;
      fill <= '0;
    end else begin
      if (do_push) begin
        wr_idx <= wr_idx + 1'b1;
      end
      if (do_pop) begin
        rd_idx <= rd_idx + 1'b1; // R7
      end
      if (do_push && !do_pop) begin
        fill <= fill + 1'b1;
      end else if (do_pop && !do_push) begin
        fill <= fill - 1'b1;
      end
    end
  end

endmodule // sucal_errq

// ---- sucal_checker.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// port checker
// ----------------------------------------
module sucal_checker (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, low
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wready, // w ready
  input wire logic s_axi_bvalid, // write answer
  input wire logic s_axi_bready, // answer taken
  input wire logic s_axi_arvalid, // read request
  input wire logic s_axi_arready, // read ready
  input wire logic s_axi_rvalid, // read answer
  input wire logic s_axi_rready, // answer taken
  input wire logic user_wavelength_cal_entry // entry flag
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // read taken and read closed
  sequence rd_take; s_axi_arvalid && s_axi_arready; endsequence
  sequence rd_done; s_axi_rvalid && s_axi_rready; endsequence
  a_read_answer: assert property (rd_take |=> s_axi_rvalid) else $error("late read");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("r");
  a_read_close: assert property (rd_done |=> !s_axi_rvalid && s_axi_arready) else $error("rc");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar busy");
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("b");
  a_write_close: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready)
    else $error("wc");
  // entry only moves when a command write completes, never from local side
  a_entry_rise: assert property ($rose(user_wavelength_cal_entry) |-> $rose(s_axi_bvalid))
    else $error("entry");
  a_entry_fall: assert property ($fell(user_wavelength_cal_entry) |-> $rose(s_axi_bvalid))
    else $error("exit");
endmodule // sucal_checker
bind sucal_top sucal_checker u_chk (.*);

// ---- sucal_remote_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// remote controller: mode pin and wavelength
// ----------------------------------------
module sucal_remote_model (
  input wire logic aclk, // clock
  input wire logic go_remote, // bench asks for remote
  input wire logic [31:0] go_wl_pm, // bench asks for wavelength
  output logic remote_pin = 1'b0, // remote mode, lags one edge
  output logic [31:0] set_wl_pm = 32'h0 // set wavelength
);
  // moves only after its own edge, like a real controller
  always @(posedge aclk) begin
    remote_pin <= go_remote;
    set_wl_pm <= go_wl_pm;
  end
endmodule // sucal_remote_model

// ---- status_and_user_cal_entry_test.sv ----
`timescale 1ns/1ps
module status_and_user_cal_entry_test;
  // ----------------------------------------
  // signals, named as the ports
  // ----------------------------------------
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, go_remote = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, go_wl_pm = 32'h0013_d620; // 1300 nm, inside range
  logic [3:0] s_axi_wstrb = 4'hf; // whole words only
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, remote_pin;
  logic stb_ques_summary, user_wavelength_cal_entry;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, set_wl_pm;
  logic [31:0] bs [6] = '{32'h124f7f, 32'h124f80, 32'h124f80, 32'h124f80, 32'h124f80, 32'h124f80};
  logic [31:0] bp [6] = '{32'h3e8, 32'h63, 32'h2711, 32'h3e8, 32'h3e8, 32'h466};
  logic [15:0] bc [6] = '{16'h0a, 16'h0a, 16'h0a, 16'h09, 16'h192, 16'h191};
  int failures = 0, num_checks = 0;
  sucal_top uut (.*);
  sucal_remote_model ctl (.*);
  initial forever #5 aclk = ~aclk;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task give_verdict();
    if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask
  // readies sampled mid-cycle, released after the edge that took them
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
    logic ta, tw, tb;
    logic [1:0] r;
    tb = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (int i = 0; i < 40 && !tb; i++) begin
      @(negedge aclk);
      {ta, tw, tb, r} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
      @(posedge aclk);
      s_axi_awvalid <= s_axi_awvalid & !ta;
      s_axi_wvalid <= s_axi_wvalid & !tw;
    end
    s_axi_bready <= 1'b0;
    if (!tb) begin failures++; give_verdict(); end
    chk("bresp", {30'h0, r}, {30'h0, e});
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] q = 2'h0);
    logic ta, tv;
    logic [1:0] r;
    logic [31:0] d;
    tv = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (int i = 0; i < 40 && !tv; i++) begin
      @(negedge aclk);
      {ta, tv, d, r} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
      @(posedge aclk);
      s_axi_arvalid <= s_axi_arvalid & !ta;
    end
    s_axi_rready <= 1'b0;
    if (!tv) begin failures++; give_verdict(); end
    chk($sformatf("reg %h", a), d, e);
    chk("rresp", {30'h0, r}, {30'h0, q});
  endtask
  task go(input logic [31:0] s, input logic [31:0] p, input logic [15:0] c);
    wr(sucal_pkg::UCAL_START_OFS, s);
    wr(sucal_pkg::UCAL_STEP_OFS, p);
    wr(sucal_pkg::UCAL_COUNT_OFS, {16'h0, c});
    wr(sucal_pkg::CMD_OFS, 32'h1 << sucal_pkg::CMD_START_BIT);
  endtask
  task wl(input logic [31:0] v);
    go_wl_pm <= v;
    repeat (6) @(posedge aclk);
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(sucal_pkg::QPTR_OFS, 0);
    rd(sucal_pkg::QNTR_OFS, 0);
    wr(sucal_pkg::QNTR_OFS, 32'h100);
    wr(sucal_pkg::QPTR_OFS, 32'h1234);
    rd(sucal_pkg::QNTR_OFS, 32'h100);
    rd(sucal_pkg::QPTR_OFS, 32'h1234);
    wr(8'h3c, 32'h0, sucal_pkg::RESP_SLVERR);
    rd(8'h3c, 0, sucal_pkg::RESP_SLVERR);
    wr(sucal_pkg::CMD_OFS, 32'h1 << sucal_pkg::CMD_PRESET_BIT);
    for (int i = 0; i < 6; i++) rd(8'h08 + 8'(4 * i), (i % 3 == 1) ? 32'hffff : 0);
    go(32'h124f80, 32'h3e8, 16'h0a); // local mode: ignored
    rd(sucal_pkg::STATUS_OFS, 0);
    go_remote <= 1'b1;
    wr(sucal_pkg::UCAL_STATE_OFS, 32'h1);
    go(32'h124f80, 32'h3e8, 16'h0a);
    wr(sucal_pkg::UCAL_STATE_OFS, 32'h0);
    for (int i = 0; i < 6; i++) go(bs[i], bp[i], bc[i]);
    rd(sucal_pkg::ERR_OFS, 32'(sucal_pkg::ERR_CAL_ON));
    for (int i = 0; i < 6; i++) rd(sucal_pkg::ERR_OFS, 32'hffff_ff23);
    rd(sucal_pkg::ERR_OFS, 0);
    go(32'h124f80, 32'h465, 16'h191); // last point exactly at the top limit
    rd(sucal_pkg::STATUS_OFS, 32'h5);
    chk("entry", {31'h0, user_wavelength_cal_entry}, 1);
    wr(sucal_pkg::QENABLE_OFS, 32'h100);
    wl(32'h0010_c8e0);
    rd(sucal_pkg::QCOND_OFS, 32'h100);
    rd(sucal_pkg::QCOND_OFS, 32'h100);
    @(negedge aclk);
    chk("summary", {31'h0, stb_ques_summary}, 1);
    wl(32'h0013_d620);
    rd(sucal_pkg::QEVENT_OFS, 32'h100);
    rd(sucal_pkg::QEVENT_OFS, 0);
    @(negedge aclk);
    chk("summary", {31'h0, stb_ques_summary}, 0);
    wr(sucal_pkg::QNTR_OFS, 32'h100);
    wr(sucal_pkg::QPTR_OFS, 32'h0);
    wl(32'h0010_c8e0);
    wl(32'h0013_d620);
    rd(sucal_pkg::QEVENT_OFS, 32'h100);
    repeat (2) wr(sucal_pkg::CMD_OFS, 32'h1 << sucal_pkg::CMD_STOP_BIT);
    chk("entry", {31'h0, user_wavelength_cal_entry}, 0);
    rd(sucal_pkg::ERR_OFS, 32'(sucal_pkg::ERR_NOT_STARTED));
    give_verdict();
  end
endmodule // status_and_user_cal_entry_test
